// *** logic/p1g_port_gpio.sv ***
// Eight-bit port with output latch, direction control, alternate functions and pull-ups.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Eight pins with output latch; direction bit 1 is input, 0 output.
// - Reset makes every pin an input, buffers off; latch value undefined.
// - Software may read the level of any pin whose direction bit is 1, whatever its alternate function.
// - Pins 0 and 1 carry pulse outputs when their enables are set.
// - Pin 2 select bit routes baud clock or serial clock to pin 2.
// - Pin 3 select bit routes receive or serial data input to pin 3.
// - Pin 4 select bit routes transmit or serial data output to pin 4; the code drives only uart2TransmitOut there.
// - Pins 5 to 7 are always plain port pins under direction control.
// - Alternate select register at 0FF41H, reset 00H, three bits implemented.
// - Output pins drive latch value, reads return latch, value persists.
// - Writes load every latch bit; input bits read the pin level.
// - Switching a bit to output drives the stored latch value immediately.
// - Alternate mode carries peripheral signal regardless of direction, per pin.
// - Peripheral output read: pin level if direction 1, internal signal if 0.
// - Peripheral input with direction 1 reads the pin level.
// - Pull-up on only when group option bit and direction bit are 1.
// - Pull-up also applies to peripheral outputs; clear direction to avoid.
// - Bit instructions do full 8-bit read-modify-write; software must take care.
module p1g_port_gpio
    import p1g_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire p1g_pkg::p1g_bus_req_t busReq,
    output logic [7:0] rdData,
    input wire logic [7:0] padIn,
    output logic [7:0] padOut,
    output logic [7:0] padOe_n,
    output logic [7:0] pullupEn,
    input wire p1g_pkg::p1g_periph_drive_t periphDrive,
    output p1g_pkg::p1g_periph_sense_t periphSense
);

    import p1g_pkg::*;

    // A low clock enable freezes every register below, the pad filter too,
    // so a pad that changes while the block is frozen is seen only once the
    // enable returns; a short pulse in that time is lost.

    // Software-visible state.
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [7:0] dir_q;
    logic [7:0] dir_d;
    logic [2:0] altSel_q;
    logic [2:0] altSel_d;
    logic pullupOpt_q;
    logic pullupOpt_d;

    // Pin input conditioning.
    logic [7:0] padSync1_q;
    logic [7:0] padSync2_q;
    logic [7:0] padSync3_q;
    logic [7:0] padLevel_q;
    logic [7:0] padLevel_d;
    logic [7:0] padAgree;

    // Per-pin view of the alternate functions.
    logic [7:0] altMode;
    logic [7:0] altDrive;
    logic [7:0] altValue;

    // Next values of the registered outputs.
    logic [7:0] padOut_d;
    logic [7:0] padOe_n_d;
    logic [7:0] pullupEn_d;
    logic [7:0] portRead;
    logic [7:0] rdData_d;

    // Address decode. The latch, direction, alternate select and pull-up option
    // offsets all live in the package, so that a system map can move any of
    // them. An address that hits none of
    // them writes nothing and reads as zero.
    logic hitLatch;
    logic hitDir;
    logic hitAlt;
    logic hitPullup;

    assign hitLatch = busReq.addr == P1G_OFF_LATCH;
    assign hitDir = busReq.addr == P1G_OFF_DIR;
    assign hitAlt = busReq.addr == P1G_OFF_ALT;
    assign hitPullup = busReq.addr == P1G_OFF_PULLUP;

    // A write loads all eight latch bits, whatever mode each pin is in, so a
    // bit-level read-modify-write by software rewrites input-mode bits with
    // the pin level it read back.
    always_comb
    begin
        latch_d = latch_q;
        if (busReq.wrStrobe && hitLatch)
        begin
            latch_d = busReq.wrData;
        end
    end

    // The latch is cleared on reset only to keep unknowns out of simulation.
    // Software must still treat its content as undefined until it writes it,
    // because a pin switched to output right after reset drives whatever the
    // latch holds.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            latch_q <= P1G_LATCH_RST;
        end
        else if (clkEn)
        begin
            latch_q <= latch_d;
        end
    end

    always_comb
    begin
        dir_d = dir_q;
        if (busReq.wrStrobe && hitDir)
        begin
            dir_d = busReq.wrData;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dir_q <= P1G_DIR_RST;
        end
        else if (clkEn)
        begin
            dir_q <= dir_d;
        end
    end

    always_comb
    begin
        altSel_d = altSel_q;
        if (busReq.wrStrobe && hitAlt)
        begin
            altSel_d = busReq.wrData[P1G_ALT_PIN4_BIT:P1G_ALT_PIN2_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            altSel_q <= P1G_ALT_RST[P1G_ALT_PIN4_BIT:P1G_ALT_PIN2_BIT];
        end
        else if (clkEn)
        begin
            altSel_q <= altSel_d;
        end
    end

    always_comb
    begin
        pullupOpt_d = pullupOpt_q;
        if (busReq.wrStrobe && hitPullup)
        begin
            pullupOpt_d = busReq.wrData[P1G_PULLUP_GRP1_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pullupOpt_q <= P1G_PULLUP_RST[P1G_PULLUP_GRP1_BIT];
        end
        else if (clkEn)
        begin
            pullupOpt_q <= pullupOpt_d;
        end
    end

    // Three-stage synchroniser; a new level is accepted only when stages two
    // and three agree, which rejects a single-cycle glitch on the pad.
    // The first stage feeds nothing but the second, so it may go metastable.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            padSync1_q <= P1G_ZERO8;
            padSync2_q <= P1G_ZERO8;
            padSync3_q <= P1G_ZERO8;
        end
        else if (clkEn)
        begin
            padSync1_q <= padIn;
            padSync2_q <= padSync1_q;
            padSync3_q <= padSync2_q;
        end
    end

    // The filtered level starts at zero after reset, so a pad that is already
    // high shows up as a rising change four edges later; a peripheral that
    // counts edges must not be enabled before then.
    always_comb
    begin
        padAgree = ~(padSync2_q ^ padSync3_q);
        padLevel_d = (padSync2_q & padAgree) | (padLevel_q & ~padAgree);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            padLevel_q <= P1G_ZERO8;
        end
        else if (clkEn)
        begin
            padLevel_q <= padLevel_d;
        end
    end

    // Which pins are handed to a peripheral, whether the peripheral drives
    // them, and with what value.
    always_comb
    begin
        altMode = P1G_ZERO8;
        altMode[P1G_PIN_PULSE0] = periphDrive.pulseOut0Enable;
        altMode[P1G_PIN_PULSE1] = periphDrive.pulseOut1Enable;
        altMode[P1G_PIN_SCLK] = altSel_q[P1G_ALT_PIN2_BIT - P1G_ALT_PIN2_BIT];
        altMode[P1G_PIN_RXD] = altSel_q[P1G_ALT_PIN3_BIT - P1G_ALT_PIN2_BIT];
        altMode[P1G_PIN_TXD] = altSel_q[P1G_ALT_PIN4_BIT - P1G_ALT_PIN2_BIT];

        // Pin 3 is never driven here, since both of its peripheral uses are
        // inputs; pin 2 is driven only while the serial block is clock master.
        altDrive = P1G_ZERO8;
        altDrive[P1G_PIN_PULSE0] = 1'b1;
        altDrive[P1G_PIN_PULSE1] = 1'b1;
        altDrive[P1G_PIN_SCLK] = periphDrive.sio2SerialClockDrive;
        altDrive[P1G_PIN_RXD] = 1'b0;
        altDrive[P1G_PIN_TXD] = 1'b1;

        altValue = P1G_ZERO8;
        altValue[P1G_PIN_PULSE0] = periphDrive.pulseOut0;
        altValue[P1G_PIN_PULSE1] = periphDrive.pulseOut1;
        altValue[P1G_PIN_SCLK] = periphDrive.sio2SerialClockOut;
        altValue[P1G_PIN_TXD] = periphDrive.uart2TransmitOut;
    end

    // Pin drive and read-back per bit. The serial clock pin counts as a
    // peripheral output only while the serial block drives it. A driven
    // peripheral pin with direction bit 0 reads back the internal signal, so
    // software sees what the peripheral means to send even if the board
    // overloads the pad; with direction bit 1, or on a pin the peripheral
    // only listens to, the filtered pad level comes back instead.
    always_comb
    begin
        padOut_d = P1G_ZERO8;
        padOe_n_d = P1G_OE_N_RST;
        portRead = P1G_ZERO8;
        for (int i = 0; i < P1G_PORT_W; i++)
        begin
            if (altMode[i])
            begin
                padOut_d[i] = altValue[i];
                padOe_n_d[i] = ~altDrive[i];
                if (dir_q[i] || !altDrive[i])
                begin
                    portRead[i] = padLevel_q[i];
                end
                else
                begin
                    portRead[i] = altValue[i];
                end
            end
            else
            begin
                padOut_d[i] = latch_q[i];
                padOe_n_d[i] = dir_q[i];
                if (dir_q[i])
                begin
                    portRead[i] = padLevel_q[i];
                end
                else
                begin
                    portRead[i] = latch_q[i];
                end
            end
        end
    end

    // Pull-ups follow the direction bit even for pins a peripheral drives.
    // Software that wants no pull-up on such a pin has to clear its direction
    // bit, which does not take the pin away from the peripheral.
    always_comb
    begin
        pullupEn_d = {P1G_PORT_W{pullupOpt_q}} & dir_q;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            padOut <= P1G_ZERO8;
            padOe_n <= P1G_OE_N_RST;
            pullupEn <= P1G_ZERO8;
        end
        else if (clkEn)
        begin
            padOut <= padOut_d;
            padOe_n <= padOe_n_d;
            pullupEn <= pullupEn_d;
        end
    end

    // Pin levels go back to the serial block whether or not it owns the pin.
    // The bundle is registered, so it trails the filtered level by one edge.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            periphSense <= '0;
        end
        else if (clkEn)
        begin
            periphSense.uart2BaudClockIn <= padLevel_q[P1G_PIN_SCLK];
            periphSense.uart2ReceiveIn <= padLevel_q[P1G_PIN_RXD];
            periphSense.pinLevel <= padLevel_q;
        end
    end

    // Read data stand for exactly one cycle and are zero otherwise, so an
    // unmapped address and an idle bus both read as zero.
    // While the clock enable is low the last reply stays on the port and a
    // strobe is dropped, so a master must not stall the block mid-access.
    always_comb
    begin
        rdData_d = P1G_ZERO8;
        if (busReq.rdStrobe)
        begin
            if (hitLatch)
            begin
                rdData_d = portRead;
            end
            else if (hitDir)
            begin
                rdData_d = dir_q;
            end
            else if (hitAlt)
            begin
                rdData_d[P1G_ALT_PIN4_BIT:P1G_ALT_PIN2_BIT] = altSel_q;
            end
            else if (hitPullup)
            begin
                rdData_d[P1G_PULLUP_GRP1_BIT] = pullupOpt_q;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdData <= P1G_ZERO8;
        end
        else if (clkEn)
        begin
            rdData <= rdData_d;
        end
    end

endmodule // p1g_port_gpio

`default_nettype wire

// *** logic/p1g_pkg.sv ***
// Package with the address map, reset values, field positions and carriers of the port.
package p1g_pkg;

    localparam int P1G_ADDR_W = 16;
    localparam int P1G_PORT_W = 8;

    localparam logic [15:0] P1G_OFF_LATCH = 16'hff01;
    localparam logic [15:0] P1G_OFF_DIR = 16'hff21;
    localparam logic [15:0] P1G_OFF_ALT = 16'hff41;
    localparam logic [15:0] P1G_OFF_PULLUP = 16'hff0e;

    localparam logic [7:0] P1G_LATCH_RST = 8'h00;
    localparam logic [7:0] P1G_DIR_RST = 8'hff;
    localparam logic [7:0] P1G_ALT_RST = 8'h00;
    localparam logic [7:0] P1G_PULLUP_RST = 8'h00;
    localparam logic [7:0] P1G_OE_N_RST = 8'hff;
    localparam logic [7:0] P1G_ZERO8 = 8'h00;

    localparam int P1G_ALT_PIN2_BIT = 2;
    localparam int P1G_ALT_PIN3_BIT = 3;
    localparam int P1G_ALT_PIN4_BIT = 4;
    localparam int P1G_PULLUP_GRP1_BIT = 1;

    localparam int P1G_PIN_PULSE0 = 0;
    localparam int P1G_PIN_PULSE1 = 1;
    localparam int P1G_PIN_SCLK = 2;
    localparam int P1G_PIN_RXD = 3;
    localparam int P1G_PIN_TXD = 4;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } p1g_bus_req_t;

    typedef struct packed {
        logic pulseOut0Enable;
        logic pulseOut1Enable;
        logic pulseOut0;
        logic pulseOut1;
        logic sio2SerialClockOut;
        logic sio2SerialClockDrive;
        logic uart2TransmitOut;
    } p1g_periph_drive_t;

    typedef struct packed {
        logic uart2BaudClockIn;
        logic uart2ReceiveIn;
        logic [7:0] pinLevel;
    } p1g_periph_sense_t;

endpackage

// *** tb/p1g_port_gpio_properties.sv ***
// Checker for pin drive, pull-ups and register read-back of the port.
`timescale 1ns/100ps
`default_nettype none
module p1g_port_gpio_properties
    import p1g_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire p1g_pkg::p1g_bus_req_t busReq,
    input wire logic [7:0] rdData,
    input wire logic [7:0] padIn,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe_n,
    input wire logic [7:0] pullupEn,
    input wire p1g_pkg::p1g_periph_drive_t periphDrive,
    input wire p1g_pkg::p1g_periph_sense_t periphSense
);
    logic [7:0] dir_q;
    logic [4:2] alt_q;
    logic opt_q;
    logic wrEn;
    logic rdEn;
    assign wrEn = clkEn && busReq.wrStrobe;
    assign rdEn = clkEn && busReq.rdStrobe;
    // Shadows of what software wrote, since the checker cannot see the registers.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dir_q <= P1G_DIR_RST;
            alt_q <= 3'h0;
            opt_q <= 1'b0;
        end
        else if (wrEn)
        begin
            if (busReq.addr == P1G_OFF_DIR) dir_q <= busReq.wrData;
            if (busReq.addr == P1G_OFF_ALT) alt_q <= busReq.wrData[4:2];
            if (busReq.addr == P1G_OFF_PULLUP) opt_q <= busReq.wrData[1];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_rd_idle_zero: assert property (clkEn && $past(clkEn) && !$past(rdEn)
        |-> rdData == P1G_ZERO8) else $error("read data outside reply");
    a_alt_readback: assert property (rdEn && busReq.addr == P1G_OFF_ALT
        |=> rdData == {3'h0, alt_q, 2'h0}) else $error("alt select read-back");
    a_pullup_rule: assert property (clkEn
        |=> pullupEn == ($past(dir_q) & {8{$past(opt_q)}})) else $error("pull-up enable");
    a_dir_oe_port: assert property (clkEn
        |=> ((padOe_n ^ $past(dir_q)) & 8'he0) == 8'h00) else $error("pins 5 to 7 enable");
    a_pulse_out0_route: assert property (clkEn && periphDrive.pulseOut0Enable
        |=> !padOe_n[0] && padOut[0] == $past(periphDrive.pulseOut0)) else $error("pulse_out0 route");
    a_pulse_out1_route: assert property (clkEn && periphDrive.pulseOut1Enable
        |=> !padOe_n[1] && padOut[1] == $past(periphDrive.pulseOut1)) else $error("pulse_out1 route");
    a_sclk_drive: assert property (clkEn && alt_q[2]
        |=> padOe_n[2] == !$past(periphDrive.sio2SerialClockDrive)) else $error("pin 2 drive");
    a_rxd_no_drive: assert property (clkEn && alt_q[3] |=> padOe_n[3])
        else $error("pin 3 driven");
    a_txd_route: assert property (clkEn && alt_q[4]
        |=> !padOe_n[4] && padOut[4] == $past(periphDrive.uart2TransmitOut)) else $error("txd");
    c_alt_write: cover property (wrEn && busReq.addr == P1G_OFF_ALT);
    c_pwm_on: cover property (periphDrive.pulseOut0Enable);
    c_pull_on: cover property (pullupEn != P1G_ZERO8);
endmodule // p1g_port_gpio_properties
bind p1g_port_gpio p1g_port_gpio_properties p1g_port_gpio_properties_inst (.ref_clk(ref_clk),
    .rst(rst), .clkEn(clkEn), .busReq(busReq), .rdData(rdData), .padIn(padIn), .padOut(padOut),
    .padOe_n(padOe_n), .pullupEn(pullupEn), .periphDrive(periphDrive),
    .periphSense(periphSense));
`default_nettype wire

// *** tb/p1g_board_model.sv ***
// Board model that resolves each pad from device drive, board drive and pull-up.
`timescale 1ns/100ps
`default_nettype none
module p1g_board_model
(
    input wire logic ref_clk,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe_n,
    input wire logic [7:0] pullupEn,
    input wire logic [7:0] boardEn,
    input wire logic [7:0] boardDrv,
    output logic [7:0] padIn
);
    logic wander_q = 1'b0;
    always @(posedge ref_clk) wander_q <= ~wander_q;
    // A floating pad wanders each cycle, so no check may lean on its level.
    always_comb
        for (int i = 0; i < 8; i++)
            padIn[i] = !padOe_n[i] ? padOut[i] : boardEn[i] ? boardDrv[i] :
                pullupEn[i] ? 1'b1 : wander_q;
endmodule // p1g_board_model
`default_nettype wire

// *** tb/p1g_port_gpio_test.sv ***
// Self-checking bench for latch, direction, alternate functions and pull-ups.
`timescale 1ns/100ps
`default_nettype none
module p1g_port_gpio_test;
    import p1g_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    p1g_bus_req_t busReq = '0;
    p1g_periph_drive_t periphDrive = '0;
    p1g_periph_sense_t periphSense;
    logic [7:0] boardEn = 8'hff;
    logic [7:0] boardDrv = 8'h3c;
    logic [7:0] rdData, padIn, padOut, padOe_n, pullupEn;
    int n_fail = 0;
    int n_checks = 0;
    always #4 ref_clk = ~ref_clk;
    p1g_port_gpio p1g_port_gpio_inst (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
        .busReq(busReq), .rdData(rdData), .padIn(padIn), .padOut(padOut), .padOe_n(padOe_n),
        .pullupEn(pullupEn), .periphDrive(periphDrive), .periphSense(periphSense));
    p1g_board_model p1g_board_model_inst (.ref_clk(ref_clk), .padOut(padOut),
        .padOe_n(padOe_n), .pullupEn(pullupEn), .boardEn(boardEn), .boardDrv(boardDrv),
        .padIn(padIn));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        busReq.wrStrobe <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        busReq.rdStrobe <= 1'b0;
        #1 chk(rdData, exp);
    endtask
    // Pad levels pass a synchroniser, so give them time to land.
    task automatic settle;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_reset;
        chk(padOe_n, P1G_OE_N_RST);
        chk(pullupEn, P1G_ZERO8);
        rd_chk(P1G_OFF_ALT, P1G_ALT_RST);
        rd_chk(P1G_OFF_DIR, P1G_DIR_RST);
        rd_chk(16'hff00, P1G_ZERO8);
    endtask
    task automatic t_port;
        wr(P1G_OFF_LATCH, 8'ha5);
        settle;
        chk(padOe_n, 8'hff);
        wr(P1G_OFF_DIR, 8'hf0);
        settle;
        chk(padOut, 8'ha5);
        chk(padOe_n, 8'hf0);
        rd_chk(P1G_OFF_LATCH, 8'h35);
    endtask
    task automatic t_alt;
        @(posedge ref_clk);
        periphDrive <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        wr(P1G_OFF_ALT, 8'hff);
        settle;
        chk(padOe_n, 8'hec);
        chk(padOut & 8'h13, 8'h01);
        chk({7'h0, periphSense.uart2ReceiveIn}, 8'h01);
        chk(periphSense.pinLevel, 8'h2d);
        chk({6'h0, periphSense.uart2BaudClockIn, periphSense.uart2ReceiveIn}, 8'h03);
        rd_chk(P1G_OFF_ALT, 8'h1c);
        rd_chk(P1G_OFF_LATCH, 8'h2d);
    endtask
    task automatic t_pull;
        wr(P1G_OFF_PULLUP, 8'h02);
        settle;
        chk(pullupEn, 8'hf0);
        boardEn <= 8'h7f;
        settle;
        chk({7'h0, periphSense.pinLevel[7]}, 8'h01);
        boardEn <= 8'hff;
        @(posedge ref_clk);
        periphDrive <= '0;
        wr(P1G_OFF_DIR, 8'he0);
        wr(P1G_OFF_ALT, P1G_ZERO8);
        settle;
        chk(pullupEn, 8'he0);
        chk(padOe_n, 8'he0);
        chk(padOut, 8'ha5);
    endtask
    // A write made while the clock enable is low must be dropped.
    task automatic t_freeze;
        @(posedge ref_clk);
        clkEn <= 1'b0;
        wr(P1G_OFF_DIR, P1G_ZERO8);
        clkEn <= 1'b1;
        rd_chk(P1G_OFF_DIR, 8'he0);
        chk(padOe_n, 8'he0);
    endtask
    // A reset in mid-run must return every pin to input with no pull-up.
    task automatic t_rereset;
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(padOe_n, P1G_OE_N_RST);
        chk(pullupEn, P1G_ZERO8);
        rd_chk(P1G_OFF_DIR, P1G_DIR_RST);
        rd_chk(P1G_OFF_PULLUP, P1G_ZERO8);
    endtask
    task automatic test_done;
        $display("Checks %0d, failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset;
        t_port;
        t_alt;
        t_pull;
        t_freeze;
        t_rereset;
        test_done;
    end
    initial
    begin
        #100000;
        n_fail++;
        test_done;
    end
endmodule // p1g_port_gpio_test
`default_nettype wire
